// >>> acpr_pkg.sv
/*
  constants, register map and carrier types for the front-end clock, power and
  error register bank.
  assumes one 40 MHz clock and a plain strobe register port with 8-bit data.
*/
package acpr_pkg;

  localparam int          ADDR_W = 8;
  localparam int          DATA_W = 8;

  // register offsets
  localparam logic [7:0]  OFS_CLK_SRC   = 8'h12;
  localparam logic [7:0]  OFS_RATE_RES  = 8'h13;
  localparam logic [7:0]  OFS_PWR_DOWN  = 8'h14;
  localparam logic [7:0]  OFS_FAULT_CN  = 8'h15;
  localparam logic [7:0]  OFS_PACE_CN   = 8'h17;
  localparam logic [7:0]  OFS_LEAD_OFF  = 8'h18;
  localparam logic [7:0]  OFS_SUMMARY   = 8'h19;
  localparam logic [7:0]  OFS_CH1_RANGE = 8'h1a;

  // writable bit masks
  localparam logic [7:0]  MSK_CLK_SRC   = 8'h07;
  localparam logic [7:0]  MSK_RATE_RES  = 8'h3f;
  localparam logic [7:0]  MSK_PWR_DOWN  = 8'h3f;
  localparam logic [7:0]  MSK_FAULT_CN  = 8'h07;
  localparam logic [7:0]  MSK_PACE_CN   = 8'h07;

  // values after reset
  localparam logic [7:0]  RST_CLK_SRC   = 8'h00;
  localparam logic [7:0]  RST_RATE_RES  = 8'h00;
  localparam logic [7:0]  RST_PWR_DOWN  = 8'h00;
  localparam logic [7:0]  RST_FAULT_CN  = 8'h00;
  localparam logic [7:0]  RST_PACE_CN   = 8'h01;
  localparam logic [7:0]  RST_STATUS    = 8'h00;

  // field positions
  localparam int          BIT_GATE      = 2;
  localparam int          BIT_OSC_OFF   = 1;
  localparam int          BIT_CLK_DRV   = 0;
  localparam int          BIT_PACE_DRV  = 2;
  localparam int          BIT_PACE_CT   = 1;
  localparam int          BIT_PACE_PD   = 0;
  localparam int          FS_LSB        = 3;
  localparam int          NCH           = 3;

  // modulator clock rates per channel setting
  localparam int          MOD_RATE_SLOW_HZ = 102400;
  localparam int          MOD_RATE_FAST_HZ = 204800;

  // live detector conditions of channel 1 range status
  typedef struct packed {
    logic mod_over;       // modulator over-range
    logic polarity;       // 1 when positive output is smaller
    logic neg_low;        // negative output near low rail
    logic neg_high;       // negative output near high rail
    logic pos_low;        // positive output near low rail
    logic pos_high;       // positive output near high rail
    logic diff_over;      // differential output out of range
  } acpr_range_t;

  // live summary conditions
  typedef struct packed {
    logic        sync_edge_fault;
    logic [2:0]  channel_range_fault; // ch3, ch2, ch1
    logic        battery_low_flag;
    logic        leg_drive_near_rail;
    logic        common_mode_out_of_range;
  } acpr_misc_t;

  // analog control outputs
  typedef struct packed {
    logic [2:0]  channel_fast_modulator_clock;
    logic [2:0]  amp_high_resolution;
    logic [2:0]  modulator_power_down;
    logic [2:0]  amp_power_down;
    logic [2:0]  amp_fault_check_disable;
    logic        pace_to_drive_input;
    logic        leg_drive_to_reference;
    logic        pace_to_central_terminal;
    logic        reference_terminal_to_pin;
    logic        pace_channel_power_down;
  } acpr_ctrl_t;

endpackage

// >>> acpr_regs.sv
/*
  register bank of the three-channel front end: clock source and gating,
  front-end rate, resolution, power and fault controls, pace routing, and the
  gated error status words.

  what the bank holds:
    0x12  clock control: digital clock gate, oscillator-off select and the
          clock pin driver enable; the crystal enable is derived as the
          inverse of the oscillator-off select
    0x13  per-channel fast modulator clock select and amplifier
          high-resolution enables
    0x14  per-channel modulator and amplifier power-down
    0x15  per-channel amplifier fault check disable
    0x17  pace routing and pace channel power-down; the power-down bit is
          the only control bit that comes out of reset set
    0x18  lead-off flags, input six down to input one
    0x19  summary error flags
    0x1a  channel 1 range flags

  behaviour worth knowing:
    - status words follow the live detector levels; they are not sticky,
      so there is no set/clear race and a read has no side effect
    - status capture is frozen while the gate bit is clear; the words then
      hold whatever they held on the last gated edge
    - every output is a flop, so derived outputs trail the register bank
      by one cycle; software that needs an output settled waits two edges
    - the modulator rates are only select bits here; the dividers that make
      the real modulator clocks live in the analog wrapper

  assumes of its surroundings:
    - status inputs are synchronous to clk and already filtered
    - the bus strobes are one cycle long and never together
    - the host keeps the gate low while it moves the source select bit and
      sets the gate only once the chosen source runs; nothing here checks it
*/
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
module acpr_regs
  import acpr_pkg::*;
(
  input  wire logic              clk,                // 40 MHz clock
  input  wire logic              nrst,               // async reset, active low
  input  wire logic [ADDR_W-1:0] addr,               // register address
  input  wire logic [DATA_W-1:0] wdata,              // write data
  input  wire logic              wr,                 // write strobe
  input  wire logic              rd,                 // read strobe
  output logic      [DATA_W-1:0] rdata,              // read data, cycle after rd
  input  wire logic [5:0]        lead_off_in,        // live lead-off per input
  input  wire acpr_misc_t        misc_in,            // live summary conditions
  input  wire acpr_range_t       range_in,           // live channel 1 range
  output logic                   digital_clock_gate, // core clock enable
  output logic                   oscillator_off_select, // 1: external clock pin
  output logic                   crystal_osc_enable, // crystal oscillator on
  output logic                   clock_pin_drive_enable, // clk pin driver on
  output acpr_ctrl_t             ctrl                // analog controls
);

  logic [7:0]  clk_src_r;
  logic [7:0]  rate_res_r;
  logic [7:0]  pwr_down_r;
  logic [7:0]  fault_cn_r;
  logic [7:0]  pace_cn_r;
  logic [7:0]  lead_off_r;
  logic [7:0]  summary_r;
  logic [7:0]  range_r;
  logic [7:0]  rdata_r;
  logic        gate_out_r;
  logic        osc_off_r;
  logic        osc_en_r;
  logic        drv_en_r;
  acpr_ctrl_t  ctrl_r;

  // write decode, one strobe per writable register; the status offsets get
  // no strobe at all, so a stray write there can never disturb a flag
  wire         wr_clk   = wr && (addr == OFS_CLK_SRC);
  wire         wr_rate  = wr && (addr == OFS_RATE_RES);
  wire         wr_pwr   = wr && (addr == OFS_PWR_DOWN);
  wire         wr_fault = wr && (addr == OFS_FAULT_CN);
  wire         wr_pace  = wr && (addr == OFS_PACE_CN);

  // write data cut to the implemented bits, so reserved bits never reach a
  // flop and always read back as zero
  wire [7:0]   clk_src_wd  = wdata & MSK_CLK_SRC;
  wire [7:0]   rate_res_wd = wdata & MSK_RATE_RES;
  wire [7:0]   pwr_down_wd = wdata & MSK_PWR_DOWN;
  wire [7:0]   fault_cn_wd = wdata & MSK_FAULT_CN;
  wire [7:0]   pace_cn_wd  = wdata & MSK_PACE_CN;

  // next values of the control registers; a cycle without a write keeps them
  wire [7:0]   clk_src_nxt  = wr_clk   ? clk_src_wd  : clk_src_r;
  wire [7:0]   rate_res_nxt = wr_rate  ? rate_res_wd : rate_res_r;
  wire [7:0]   pwr_down_nxt = wr_pwr   ? pwr_down_wd : pwr_down_r;
  wire [7:0]   fault_cn_nxt = wr_fault ? fault_cn_wd : fault_cn_r;
  wire [7:0]   pace_cn_nxt  = wr_pace  ? pace_cn_wd  : pace_cn_r;

  // clock control fields under their own names
  wire         gate_bit    = clk_src_r[BIT_GATE];
  wire         osc_off_bit = clk_src_r[BIT_OSC_OFF];
  wire         clk_drv_bit = clk_src_r[BIT_CLK_DRV];

  // pace routing fields; the drive input and reference switches move as one,
  // so the leg drive amplifier is never left floating between them
  wire         pace_drv_bit = pace_cn_r[BIT_PACE_DRV];
  wire         pace_ct_bit  = pace_cn_r[BIT_PACE_CT];
  wire         pace_pd_bit  = pace_cn_r[BIT_PACE_PD];

  // status capture runs only while the digital clock is let through; the
  // register bit is used rather than the delayed output, so capture starts
  // on the edge right after the write that sets the gate
  wire         gate_on  = gate_bit;

  // channel 1 range detector conditions under their own names
  wire         modulator_over_range      = range_in.mod_over;
  wire         amp_output_polarity       = range_in.polarity;
  wire         neg_out_near_low_rail     = range_in.neg_low;
  wire         neg_out_near_high_rail    = range_in.neg_high;
  wire         pos_out_near_low_rail     = range_in.pos_low;
  wire         pos_out_near_high_rail    = range_in.pos_high;
  wire         differential_out_of_range = range_in.diff_over;

  // summary conditions under their own names
  wire         sync_edge_fault          = misc_in.sync_edge_fault;
  wire [2:0]   channel_range_fault      = misc_in.channel_range_fault;
  wire         battery_low_flag         = misc_in.battery_low_flag;
  wire         leg_drive_near_rail      = misc_in.leg_drive_near_rail;
  wire         common_mode_out_of_range = misc_in.common_mode_out_of_range;
  wire         any_lead_off             = |lead_off_in;

  // live status words in register layout; flags follow the conditions with
  // no stickiness, so clearing is by the condition going away and a read
  // never has to clear anything
  wire [7:0]   lead_off_live = {2'b00, lead_off_in};
  wire [7:0]   summary_live  = {sync_edge_fault, channel_range_fault,
                                any_lead_off, battery_low_flag,
                                leg_drive_near_rail,
                                common_mode_out_of_range};
  wire [7:0]   range_live    = {1'b0, modulator_over_range,
                                amp_output_polarity,
                                neg_out_near_low_rail,
                                neg_out_near_high_rail,
                                pos_out_near_low_rail,
                                pos_out_near_high_rail,
                                differential_out_of_range};

  // status next values; with the gate clear the words hold, which is how a
  // stopped digital clock looks from the bus
  wire [7:0]   lead_off_nxt = gate_on ? lead_off_live : lead_off_r;
  wire [7:0]   summary_nxt  = gate_on ? summary_live  : summary_r;
  wire [7:0]   range_nxt    = gate_on ? range_live    : range_r;

  // read mux; unmapped addresses read zero
  logic [7:0]  rd_mux;
  always_comb begin
    case (addr)
      OFS_CLK_SRC:   rd_mux = clk_src_r;
      OFS_RATE_RES:  rd_mux = rate_res_r;
      OFS_PWR_DOWN:  rd_mux = pwr_down_r;
      OFS_FAULT_CN:  rd_mux = fault_cn_r;
      OFS_PACE_CN:   rd_mux = pace_cn_r;
      OFS_LEAD_OFF:  rd_mux = lead_off_r;
      OFS_SUMMARY:   rd_mux = summary_r;
      OFS_CH1_RANGE: rd_mux = range_r;
      default:       rd_mux = 8'h00;
    endcase
  end

  // read data is zero outside the cycle after a read strobe
  wire [7:0]   rdata_nxt = rd ? rd_mux : 8'h00;

  // control outputs during reset follow the reset values of the bank, so the
  // pace channel is already shut down and the reference terminal connected
  localparam acpr_ctrl_t CTRL_RST = '{
    pace_channel_power_down:   RST_PACE_CN[BIT_PACE_PD],
    reference_terminal_to_pin: ~RST_PACE_CN[BIT_PACE_CT],
    default:                   '0
  };

  // clock control register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      clk_src_r <= RST_CLK_SRC;
    end else begin
      clk_src_r <= clk_src_nxt;
    end
  end

  // rate and resolution register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rate_res_r <= RST_RATE_RES;
    end else begin
      rate_res_r <= rate_res_nxt;
    end
  end

  // power-down register; all blocks active out of reset
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pwr_down_r <= RST_PWR_DOWN;
    end else begin
      pwr_down_r <= pwr_down_nxt;
    end
  end

  // fault check control register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fault_cn_r <= RST_FAULT_CN;
    end else begin
      fault_cn_r <= fault_cn_nxt;
    end
  end

  // pace routing register; the one control that resets to a set bit
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pace_cn_r <= RST_PACE_CN;
    end else begin
      pace_cn_r <= pace_cn_nxt;
    end
  end

  // lead-off status word, sampled on the gated clock
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lead_off_r <= RST_STATUS;
    end else begin
      lead_off_r <= lead_off_nxt;
    end
  end

  // summary status word, sampled on the gated clock
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      summary_r <= RST_STATUS;
    end else begin
      summary_r <= summary_nxt;
    end
  end

  // channel 1 range word, sampled on the gated clock
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      range_r <= RST_STATUS;
    end else begin
      range_r <= range_nxt;
    end
  end

  // read data register, valid the cycle after rd only
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // per-channel control bits; one loop so the three channels cannot drift
  wire [NCH-1:0] fast_clk_w;
  wire [NCH-1:0] hires_w;
  wire [NCH-1:0] mod_pd_w;
  wire [NCH-1:0] amp_pd_w;
  wire [NCH-1:0] fault_off_w;
  for (genvar g = 0; g < NCH; g++) begin : g_chan
    assign fast_clk_w[g]  = rate_res_r[FS_LSB + g];
    assign hires_w[g]     = rate_res_r[g];
    assign mod_pd_w[g]    = pwr_down_r[FS_LSB + g];
    assign amp_pd_w[g]    = pwr_down_r[g];
    assign fault_off_w[g] = fault_cn_r[g];
  end

  // analog control mapping; register outputs trail the bank by one cycle
  acpr_ctrl_t  ctrl_nxt;
  always_comb begin
    ctrl_nxt.channel_fast_modulator_clock = fast_clk_w;
    ctrl_nxt.amp_high_resolution          = hires_w;
    ctrl_nxt.modulator_power_down         = mod_pd_w;
    ctrl_nxt.amp_power_down               = amp_pd_w;
    ctrl_nxt.amp_fault_check_disable      = fault_off_w;
    ctrl_nxt.pace_to_drive_input          = pace_drv_bit;
    ctrl_nxt.leg_drive_to_reference       = pace_drv_bit;
    ctrl_nxt.pace_to_central_terminal     = pace_ct_bit;
    ctrl_nxt.reference_terminal_to_pin    = ~pace_ct_bit;
    ctrl_nxt.pace_channel_power_down      = pace_pd_bit;
  end

  // digital clock gate output
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      gate_out_r <= 1'b0;
    end else begin
      gate_out_r <= gate_bit;
    end
  end

  // oscillator-off select output
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      osc_off_r <= 1'b0;
    end else begin
      osc_off_r <= osc_off_bit;
    end
  end

  // crystal oscillator enable; off whenever the pin source is chosen, which
  // saves its current while an external clock drives the core
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      osc_en_r <= 1'b1;
    end else begin
      osc_en_r <= ~osc_off_bit;
    end
  end

  // clock pin driver enable
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      drv_en_r <= 1'b0;
    end else begin
      drv_en_r <= clk_drv_bit;
    end
  end

  // analog control word
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_r <= CTRL_RST;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  assign rdata                  = rdata_r;
  assign digital_clock_gate     = gate_out_r;
  assign oscillator_off_select  = osc_off_r;
  assign crystal_osc_enable     = osc_en_r;
  assign clock_pin_drive_enable = drv_en_r;
  assign ctrl                   = ctrl_r;

endmodule // acpr_regs

// >>> acpr_regs_asserts.sv
/* checker for acpr_regs: control outputs, read port and gated status flags.
   assumes one clock and the one-cycle read port of the bank. */
`timescale 1ns/1ps
module acpr_regs_asserts
  import acpr_pkg::*;
(
  input wire logic        clk,                    // clock
  input wire logic        nrst,                   // reset
  input wire logic [7:0]  addr,                   // address
  input wire logic [7:0]  wdata,                  // write data
  input wire logic        wr,                     // write
  input wire logic        rd,                     // read
  input wire logic [7:0]  rdata,                  // read data
  input wire logic [5:0]  lead_off_in,            // lead-off
  input wire acpr_misc_t  misc_in,                // summary
  input wire acpr_range_t range_in,               // range
  input wire logic        digital_clock_gate,     // gate
  input wire logic        oscillator_off_select,  // source
  input wire logic        crystal_osc_enable,     // crystal
  input wire logic        clock_pin_drive_enable, // pin
  input wire acpr_ctrl_t  ctrl                    // controls
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // a write shows on the outputs two edges after its strobe
  a_clk_ctrl: assert property (wr && addr == OFS_CLK_SRC |-> ##2
    {digital_clock_gate, oscillator_off_select, clock_pin_drive_enable} == $past(wdata[2:0], 2)
  ) else $error("clock control not applied");
  a_rate_res: assert property (wr && addr == OFS_RATE_RES |-> ##2
    {ctrl.channel_fast_modulator_clock, ctrl.amp_high_resolution} == $past(wdata[5:0], 2)
  ) else $error("rate or resolution not applied");
  a_power_down: assert property (wr && addr == OFS_PWR_DOWN |-> ##2
    {ctrl.modulator_power_down, ctrl.amp_power_down} == $past(wdata[5:0], 2)
  ) else $error("power down not applied");
  a_fault_ctrl: assert property (wr && addr == OFS_FAULT_CN |-> ##2
    ctrl.amp_fault_check_disable == $past(wdata[2:0], 2)) else $error("fault control lost");
  a_pace_route: assert property (ctrl.leg_drive_to_reference == ctrl.pace_to_drive_input &&
    ctrl.reference_terminal_to_pin != ctrl.pace_to_central_terminal) else $error("pace route");
  // status seen by a read was sampled two edges earlier, only with the gate set
  a_lead_off: assert property (rd && addr == OFS_LEAD_OFF && digital_clock_gate |=>
    rdata == {2'b00, $past(lead_off_in, 2)}) else $error("lead-off flags wrong");
  a_summary: assert property (rd && addr == OFS_SUMMARY && digital_clock_gate |=>
    rdata == {$past(misc_in[6:3], 2), |$past(lead_off_in, 2), $past(misc_in[2:0], 2)}
  ) else $error("summary flags wrong");
  a_range: assert property (rd && addr == OFS_CH1_RANGE && digital_clock_gate |=>
    rdata == {1'b0, $past(range_in, 2)}) else $error("range flags wrong");
  a_reserved: assert property (rd && (addr == OFS_CLK_SRC || addr == OFS_PACE_CN) |=>
    rdata[7:3] == 5'h00) else $error("reserved bits not zero");
  a_osc_pair: assert property (crystal_osc_enable != oscillator_off_select)
    else $error("crystal enable not inverse of source select");
  // main scenarios
  c_gate_on: cover property (wr && addr == OFS_CLK_SRC && wdata[BIT_GATE]);
  c_lead_read: cover property (rd && addr == OFS_LEAD_OFF && digital_clock_gate);
  c_pace_up: cover property ($fell(ctrl.pace_channel_power_down));
endmodule // acpr_regs_asserts
bind acpr_regs acpr_regs_asserts u_acpr_regs_asserts (.clk, .nrst, .addr, .wdata, .wr, .rd,
  .rdata, .lead_off_in, .misc_in, .range_in, .digital_clock_gate, .oscillator_off_select,
  .crystal_osc_enable, .clock_pin_drive_enable, .ctrl);

// >>> tb.sv
/* bench for acpr_regs: reset values, random control writes, gated status.
   assumes the bank answers a read one cycle after the strobe. */
`timescale 1ns/1ps
module tb
  import acpr_pkg::*;
;
  logic        clk, nrst, wr, rd, gate, osc_off, xtal_on, pin_on;
  logic [7:0]  addr, wdata, rdata, a, v;
  logic [5:0]  lead_off_in;
  acpr_misc_t  misc_in;
  acpr_range_t range_in;
  acpr_ctrl_t  ctrl;
  logic [7:0]  m [256];
  logic [7:0]  tbl [7] = '{OFS_CLK_SRC, OFS_RATE_RES, OFS_PWR_DOWN, OFS_FAULT_CN,
                           OFS_PACE_CN, 8'h16, OFS_LEAD_OFF};
  logic [31:0] seed, r;
  int          error_cnt, n_compared;

  acpr_regs u_acpr_regs (.clk, .nrst, .addr, .wdata, .wr, .rd, .rdata, .lead_off_in,
    .misc_in, .range_in, .digital_clock_gate(gate), .oscillator_off_select(osc_off),
    .crystal_osc_enable(xtal_on), .clock_pin_drive_enable(pin_on), .ctrl);

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // writable bits per offset; everything else but the status words reads zero
  function automatic logic [7:0] msk(input logic [7:0] x);
    return (x == OFS_CLK_SRC || x == OFS_FAULT_CN || x == OFS_PACE_CN) ? 8'h07 :
           (x == OFS_RATE_RES || x == OFS_PWR_DOWN) ? 8'h3f : 8'h00;
  endfunction
  function automatic acpr_ctrl_t cexp();
    return {m[OFS_RATE_RES][5:0], m[OFS_PWR_DOWN][5:0], m[OFS_FAULT_CN][2:0],
            m[OFS_PACE_CN][2], m[OFS_PACE_CN][2], m[OFS_PACE_CN][1], !m[OFS_PACE_CN][1],
            m[OFS_PACE_CN][0]};
  endfunction
  task automatic chk(input logic [23:0] g, e);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wreg(input logic [7:0] x, d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= x;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    if (msk(x) != 8'h00) m[x] = d & msk(x);
  endtask
  task automatic rchk(input logic [7:0] x);
    @(posedge clk);
    rd <= 1'b1;
    addr <= x;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk({16'h0, rdata}, {16'h0, m[x]});
  endtask
  // derived outputs settle one edge after the register
  task automatic ochk();
    repeat (2) @(posedge clk);
    #1 chk({21'h0, gate, osc_off, pin_on}, {16'h0, m[OFS_CLK_SRC]});
    chk({23'h0, xtal_on}, {23'h0, !m[OFS_CLK_SRC][1]});
    chk({4'h0, ctrl}, {4'h0, cexp()});
  endtask
  // new detector levels; the model follows only when sampling is enabled
  task automatic srnd(input bit upd);
    logic [31:0] s;
    s = rnd();
    s[5:0] = s[5:0] & {6{s[31]}};
    @(posedge clk);
    lead_off_in <= s[5:0];
    misc_in <= s[12:6];
    range_in <= s[19:13];
    if (upd) begin
      m[OFS_LEAD_OFF] = {2'b00, s[5:0]};
      m[OFS_SUMMARY] = {s[12:9], |s[5:0], s[8:6]};
      m[OFS_CH1_RANGE] = {1'b0, s[19:13]};
    end
    for (int k = 24; k < 27; k++) rchk(k[7:0]);
  endtask
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // a hang ends the run well past the expected few hundred cycles
  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    print_verdict();
  end
  initial begin
    {nrst, wr, rd, addr, wdata, lead_off_in, misc_in, range_in} = '0;
    seed = 32'h94ccefea;
    foreach (m[i]) m[i] = 8'h00;
    m[OFS_PACE_CN] = 8'h01;
    repeat (5) @(posedge clk);
    #1 chk({4'h0, ctrl}, {4'h0, cexp()});
    chk({23'h0, xtal_on}, {23'h0, 1'b1});
    @(posedge clk);
    nrst <= 1'b1;
    ochk();
    foreach (tbl[i]) rchk(tbl[i]);
    $display("test reset done");
    // all-ones first, then random; writes to 0x12 keep the source bit as it is, so it never moves here
    for (int i = 0; i < 40; i++) begin
      r = rnd();
      a = tbl[(i < 7) ? i : r[15:8] % 7];
      v = (i < 7) ? 8'hff : r[7:0];
      if (a == OFS_CLK_SRC) v[1] = m[a][1];
      wreg(a, v);
      rchk(a);
      ochk();
    end
    $display("test control done");
    wreg(OFS_CLK_SRC, 8'h04);
    repeat (16) srnd(1'b1);
    $display("test status done");
    wreg(OFS_CLK_SRC, 8'h00);
    srnd(1'b0);
    wreg(OFS_CLK_SRC, 8'h02);
    wreg(OFS_CLK_SRC, 8'h06);
    ochk();
    srnd(1'b1);
    $display("test freeze done");
    print_verdict();
  end
endmodule // tb
